// [pbm_regs.svh]
// Purpose: register map, field positions, reset values of loop control
// Assumes: 8-bit registers reached over a plain address/strobe port
// Notes: definitions only
// Behaviour
// [R1] Acquisition mode shows coarse indicator cleared
// [R2] Tracking whenever indicator set
// [R3] Automatic mode: detector switches filter itself
// [R4] Automatic mode: indicator read-only, writes ignored
// [R5] Indicator follows acquisition tolerance window
// [R6] Settled flag follows lock tolerance window
// [R7] Enabled interrupt on every settled flag toggle
// [R8] Manual mode: indicator is software filter control
// [R9] Software clears indicator before powering loop
// [R10] Software waits acquire time before tracking
// [R11] Software waits settle time before base select
// [R12] Manual mode: no settled flag, no interrupts
// [R13] Prescaler divides oscillator by two power P
// [R14] Loop locks to reference times 2^P*N/R
// [R15] Software never programs range exponent three
// [R16] Range centre is L*2^E nominal steps
// [R17] Software writes P,E,N,L,R into fields
// [R18] Parameters writable only with loop off
// [R19] Zero N,R act as one; zero L disables
// [R20] Base select refused while loop is off; code accepts select in the same write that clears power
// [R21] Control read clears change flag; zero manual
// [R22] Detector windows are parameters
`ifndef PBM_REGS_SVH
`define PBM_REGS_SVH
`define PBM_ADDR_CTRL 8'h36
`define PBM_ADDR_BW   8'h37
`define PBM_ADDR_MULH 8'h38
`define PBM_ADDR_MULL 8'h39
`define PBM_ADDR_LIN  8'h3a
`define PBM_ADDR_RDIV 8'h3b
`define PBM_CTRL_IE     7
`define PBM_CTRL_PWR    5
`define PBM_CTRL_BSEL   4
`define PBM_CTRL_PRE_HI 3
`define PBM_CTRL_PRE_LO 2
`define PBM_CTRL_EXP_HI 1
`define PBM_CTRL_EXP_LO 0
`define PBM_BW_AUTO   7
`define PBM_BW_COARSE 5
`define PBM_RST_PWR  1'b1
`define PBM_RST_MULT 12'h040
`define PBM_RST_LIN  8'h40
`define PBM_RST_RDIV 4'h1
`define PBM_AVG_EDGES 16'h0010
`define PBM_ACQ_TOL   16'h0004
`define PBM_LOCK_TOL  16'h0001
`endif

// [pbm_pkg.sv]
// Purpose: types of the loop bandwidth control
// Assumes: nothing
// Notes: constants live in pbm_regs.svh
package pbm_pkg;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pbm_bus_type;

  // Lock detector phases
  typedef enum logic [1:0] {
    DET_OFF  = 2'b00,
    DET_ARM  = 2'b01,
    DET_RUN  = 2'b10,
    DET_EVAL = 2'b11
  } pbm_det_type;

  // Whole state of the control block
  typedef struct packed {
    logic        irq_en;
    logic        chg_flag;
    logic        pwr;
    logic        bsel;
    logic [1:0]  pre;
    logic [1:0]  rexp;
    logic        auto_bw;
    logic        lock;
    logic        coarse;
    logic [11:0] mult;
    logic [7:0]  lin;
    logic [3:0]  rdiv;
    pbm_det_type det;
    logic [3:0]  ref_cnt;
    logic        ref_tick;
    logic [15:0] acc;
    logic [15:0] edges;
    logic        fb_prev;
    logic [7:0]  rdata;
    logic        loop_run;
    logic        irq;
    logic [11:0] mult_eff;
    logic [3:0]  rdiv_eff;
    logic [10:0] centre;
  } pbm_state_type;

  // Synchroniser state
  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } pbm_sync_type;

endpackage

// [pbm_sync.sv]
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input from a foreign clock or a pin
// Notes: level moves only when stages two and three agree
`timescale 1ns/1ns
module pbm_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      level_o
);
  import pbm_pkg::*;

  pbm_sync_type s_q;
  pbm_sync_type s_d;

  // Stage one feeds stage two only, to contain metastability
  always_comb begin
    s_d = s_q;
    s_d.stage = {s_q.stage[1:0], async_i};
    if (s_q.stage[1] == s_q.stage[2]) begin
      s_d.level = s_q.stage[1];
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.level;
endmodule

// [pbm_ctrl.sv]
// Purpose: loop filter bandwidth, lock detection and parameters
// Assumes: runs on the reference clock; feedback clock is foreign
// Notes: analog oscillator and base clock switch are outside
`timescale 1ns/1ns
`include "pbm_regs.svh"
module pbm_ctrl #(
  parameter logic [15:0] AVG_EDGES = `PBM_AVG_EDGES,
  parameter logic [15:0] ACQ_TOL   = `PBM_ACQ_TOL,
  parameter logic [15:0] LOCK_TOL  = `PBM_LOCK_TOL
) (
  input  wire logic                 CLK_SYS_I,
  input  wire logic                 RESET_I,
  input  wire pbm_pkg::pbm_bus_type BUS_I,
  output logic [7:0]                RDATA_O,
  input  wire logic                 FB_CLK_I,
  output logic                      LOOP_ON_O,
  output logic                      TRACK_O,
  output logic                      BASE_SEL_O,
  output logic [1:0]                PRESCALE_O,
  output logic [1:0]                RANGE_EXP_O,
  output logic [11:0]               MULT_O,
  output logic [3:0]                REF_DIV_O,
  output logic [7:0]                LIN_RANGE_O,
  output logic [10:0]               CENTRE_O,
  output logic                      LOCK_O,
  output logic                      IRQ_O
);
  import pbm_pkg::*;

  pbm_state_type q;
  pbm_state_type d;

  logic        fb_lvl;
  logic        fb_rise;
  logic        wr_ctrl;
  logic        wr_bw;
  logic        rd_ctrl;
  logic [15:0] err;
  logic        in_acq;
  logic        in_lock;
  logic        acc_sat;

  // Feedback clock comes from the oscillator domain
  pbm_sync u_fb_sync (
    .clk_i   (CLK_SYS_I),
    .rst_i   (RESET_I),
    .async_i (FB_CLK_I),
    .level_o (fb_lvl)
  );

  // Next-state logic
  always_comb begin
    d = q;
    d.rdata = 8'h00;
    fb_rise = fb_lvl & ~q.fb_prev;
    d.fb_prev = fb_lvl;
    wr_ctrl = BUS_I.wr && (BUS_I.addr == `PBM_ADDR_CTRL);
    wr_bw = BUS_I.wr && (BUS_I.addr == `PBM_ADDR_BW);
    rd_ctrl = BUS_I.rd && (BUS_I.addr == `PBM_ADDR_CTRL);
    acc_sat = (q.acc == 16'hffff);
    err = (q.acc >= AVG_EDGES) ? (q.acc - AVG_EDGES) : (AVG_EDGES - q.acc);
    in_acq = !acc_sat && (err <= ACQ_TOL);
    in_lock = !acc_sat && (err <= LOCK_TOL);

    // Control register write
    if (wr_ctrl) begin
      if (q.auto_bw) begin
        d.irq_en = BUS_I.wdata[`PBM_CTRL_IE];
      end
      // Power bit frozen only while base select is already set
      if (!q.bsel) begin
        d.pwr = BUS_I.wdata[`PBM_CTRL_PWR];
      end
      // Selecting needs the loop already on; never in one write
      d.bsel = BUS_I.wdata[`PBM_CTRL_BSEL] & q.pwr; // [R20]
      if (!q.pwr) begin
        d.pre = BUS_I.wdata[`PBM_CTRL_PRE_HI:`PBM_CTRL_PRE_LO]; // [R18]
        d.rexp = BUS_I.wdata[`PBM_CTRL_EXP_HI:`PBM_CTRL_EXP_LO]; // [R17]
      end
    end

    // Bandwidth register write
    if (wr_bw) begin
      d.auto_bw = BUS_I.wdata[`PBM_BW_AUTO];
      // Software owns the filter mode only in manual mode
      if (!q.auto_bw) begin
        d.coarse = BUS_I.wdata[`PBM_BW_COARSE]; // [R8] [R4]
      end
    end

    // Divider and range parameters, frozen while the loop is on
    if (BUS_I.wr && !q.pwr) begin
      if (BUS_I.addr == `PBM_ADDR_MULH) begin
        d.mult[11:8] = BUS_I.wdata[3:0]; // [R18]
      end else if (BUS_I.addr == `PBM_ADDR_MULL) begin
        d.mult[7:0] = BUS_I.wdata; // [R18]
      end else if (BUS_I.addr == `PBM_ADDR_LIN) begin
        d.lin = BUS_I.wdata; // [R18]
      end else if (BUS_I.addr == `PBM_ADDR_RDIV) begin
        d.rdiv = BUS_I.wdata[3:0]; // [R18]
      end
    end

    // Zero linear multiplier forces the oscillator clock
    if (d.lin == 8'h00) begin
      d.bsel = 1'b0; // [R19]
    end

    // Reference divider; a zero divisor counts as one
    if (!q.loop_run) begin
      d.ref_cnt = 4'h0;
      d.ref_tick = 1'b0;
    end else if (({1'b0, q.ref_cnt} + 5'h01) >= {1'b0, q.rdiv_eff}) begin
      d.ref_cnt = 4'h0;
      d.ref_tick = 1'b1;
    end else begin
      d.ref_cnt = q.ref_cnt + 4'h1;
      d.ref_tick = 1'b0;
    end

    // Frequency comparison: reference ticks over feedback periods
    case (q.det)
      DET_OFF: begin
        d.acc = 16'h0000;
        d.edges = 16'h0000;
        d.lock = 1'b0;
        if (q.auto_bw) begin
          d.coarse = 1'b0; // [R1]
        end
        if (q.loop_run) begin
          d.det = DET_ARM;
        end
      end
      DET_ARM: begin
        // Measurement starts on a feedback edge
        if (!q.loop_run) begin
          d.det = DET_OFF;
        end else if (fb_rise) begin
          d.acc = 16'h0000;
          d.edges = 16'h0000;
          d.det = DET_RUN;
        end
      end
      DET_RUN: begin
        if (!q.loop_run) begin
          d.det = DET_OFF;
        end else begin
          if (q.ref_tick && !acc_sat) begin
            d.acc = q.acc + 16'h0001;
          end
          if (fb_rise) begin
            d.edges = q.edges + 16'h0001;
          end
          // A dead feedback clock ends the window by saturation
          if ((fb_rise && (d.edges >= AVG_EDGES)) || acc_sat) begin
            d.det = DET_EVAL;
          end
        end
      end
      DET_EVAL: begin
        // Eval cycle drops at most one tick; tolerances cover it
        if (q.auto_bw) begin
          d.coarse = in_acq; // [R3] [R5]
          d.lock = in_lock; // [R6] [R22]
        end
        d.acc = 16'h0000;
        d.edges = 16'h0000;
        d.det = q.loop_run ? DET_RUN : DET_OFF;
      end
      default: begin
        d.det = DET_OFF;
      end
    endcase

    // Settled flag and enable vanish in manual mode
    if (!d.auto_bw) begin
      d.lock = 1'b0; // [R12]
      d.irq_en = 1'b0; // [R12]
    end

    // Reading control clears the flag; a new toggle wins
    if (rd_ctrl) begin
      d.chg_flag = 1'b0; // [R21]
    end
    if (d.auto_bw && (d.lock != q.lock)) begin
      d.chg_flag = 1'b1; // [R7]
    end
    if (!d.auto_bw) begin
      d.chg_flag = 1'b0; // [R21]
    end

    // Interrupt request level
    d.irq = d.chg_flag & d.irq_en & d.auto_bw; // [R7] [R12]

    // Effective loop settings seen by the analog side
    d.loop_run = d.pwr && (d.lin != 8'h00); // [R19]
    d.mult_eff = (d.mult == 12'h000) ? 12'h001 : d.mult; // [R19] [R14]
    d.rdiv_eff = (d.rdiv == 4'h0) ? 4'h1 : d.rdiv; // [R19] [R14]
    d.centre = {3'b000, d.lin} << d.rexp; // [R16]

    // Read data, valid in the cycle after the strobe
    if (BUS_I.rd) begin
      if (BUS_I.addr == `PBM_ADDR_CTRL) begin
        d.rdata = {q.irq_en & q.auto_bw, q.chg_flag & q.auto_bw,
                   q.pwr, q.bsel, q.pre, q.rexp};
      end else if (BUS_I.addr == `PBM_ADDR_BW) begin
        d.rdata = {q.auto_bw, q.lock & q.auto_bw, q.coarse, 5'b00000};
      end else if (BUS_I.addr == `PBM_ADDR_MULH) begin
        d.rdata = {4'h0, q.mult[11:8]};
      end else if (BUS_I.addr == `PBM_ADDR_MULL) begin
        d.rdata = q.mult[7:0];
      end else if (BUS_I.addr == `PBM_ADDR_LIN) begin
        d.rdata = q.lin;
      end else if (BUS_I.addr == `PBM_ADDR_RDIV) begin
        d.rdata = {4'h0, q.rdiv};
      end else begin
        d.rdata = 8'h00;
      end
    end
  end

  // State register; loop powered from reset so it can settle
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      q <= '0;
      q.pwr <= `PBM_RST_PWR;
      q.mult <= `PBM_RST_MULT;
      q.lin <= `PBM_RST_LIN;
      q.rdiv <= `PBM_RST_RDIV;
      q.det <= DET_OFF;
      q.loop_run <= 1'b1;
      q.mult_eff <= `PBM_RST_MULT;
      q.rdiv_eff <= `PBM_RST_RDIV;
      q.centre <= {3'b000, `PBM_RST_LIN};
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign RDATA_O = q.rdata;
  assign LOOP_ON_O = q.loop_run;
  // Tracking exactly when the indicator is set
  assign TRACK_O = q.coarse; // [R2]
  assign BASE_SEL_O = q.bsel;
  // Oscillator is divided by 2^P ahead of the feedback divider
  assign PRESCALE_O = q.pre; // [R13]
  assign RANGE_EXP_O = q.rexp;
  assign MULT_O = q.mult_eff;
  assign REF_DIV_O = q.rdiv_eff;
  assign LIN_RANGE_O = q.lin;
  assign CENTRE_O = q.centre;
  assign LOCK_O = q.lock;
  assign IRQ_O = q.irq;
endmodule

// [pbm_ctrl_monitor.sv]
// Purpose: port-level checks of the loop bandwidth control
// Assumes: one clock, synchronous active-high reset
// Notes: auto mode is mirrored from bus writes, it is always writable
`timescale 1ns/1ns
`include "pbm_regs.svh"
module pbm_ctrl_monitor #(
  parameter logic [15:0] AVG_EDGES = `PBM_AVG_EDGES,
  parameter logic [15:0] ACQ_TOL   = `PBM_ACQ_TOL,
  parameter logic [15:0] LOCK_TOL  = `PBM_LOCK_TOL
) (
  input wire logic                 CLK_SYS_I,
  input wire logic                 RESET_I,
  input wire pbm_pkg::pbm_bus_type BUS_I,
  input wire logic                 LOOP_ON_O,
  input wire logic                 TRACK_O,
  input wire logic                 BASE_SEL_O,
  input wire logic [1:0]           PRESCALE_O,
  input wire logic [1:0]           RANGE_EXP_O,
  input wire logic [11:0]          MULT_O,
  input wire logic [3:0]           REF_DIV_O,
  input wire logic [7:0]           LIN_RANGE_O,
  input wire logic [10:0]          CENTRE_O,
  input wire logic                 LOCK_O,
  input wire logic                 IRQ_O
);
  import pbm_pkg::*;
  logic auto_q;
  // Shadow of the auto bit, needed since it is not a port
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) auto_q <= 1'b0;
    else if (BUS_I.wr && BUS_I.addr == `PBM_ADDR_BW) auto_q <= BUS_I.wdata[7];
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  // Invariants and timed relations on the outputs
  a_mult_nonzero: assert property (MULT_O != 12'h000 && REF_DIV_O != 4'h0)
    else $error("zero divider shown");
  a_lin_zero_off: assert property (LIN_RANGE_O == 8'h00 |-> !LOOP_ON_O)
    else $error("loop on with zero range");
  a_base_needs_loop: assert property (BASE_SEL_O |-> LOOP_ON_O)
    else $error("base select without loop");
  a_centre_calc: assert property (CENTRE_O == ({3'h0, LIN_RANGE_O} << RANGE_EXP_O))
    else $error("centre mismatch");
  a_param_hold: assert property ($past(LOOP_ON_O, 2) && $past(LOOP_ON_O) && LOOP_ON_O
    |-> $stable({MULT_O, REF_DIV_O, LIN_RANGE_O, PRESCALE_O, RANGE_EXP_O}))
    else $error("parameter moved while loop on");
  a_manual_quiet: assert property (!auto_q && !$past(auto_q) |-> !LOCK_O && !IRQ_O)
    else $error("lock or irq in manual");
  a_track_set: assert property (BUS_I.wr && BUS_I.addr == `PBM_ADDR_BW && !auto_q
    && !BUS_I.wdata[7] && BUS_I.wdata[5] |-> ##[1:2] TRACK_O)
    else $error("manual tracking not taken");
  a_track_clear: assert property (BUS_I.wr && BUS_I.addr == `PBM_ADDR_BW && !auto_q
    && !BUS_I.wdata[7] && !BUS_I.wdata[5] |-> ##[1:2] !TRACK_O)
    else $error("manual acquisition not taken");
  a_irq_read_clear: assert property (BUS_I.rd && BUS_I.addr == `PBM_ADDR_CTRL
    ##1 $stable(LOCK_O) [*3] |-> !IRQ_O)
    else $error("irq kept after control read");
  c_lock: cover property ($rose(LOCK_O));
  c_unlock: cover property ($fell(LOCK_O));
  c_irq: cover property ($rose(IRQ_O));
  c_base: cover property ($rose(BASE_SEL_O));
endmodule
bind pbm_ctrl pbm_ctrl_monitor #(.AVG_EDGES(AVG_EDGES), .ACQ_TOL(ACQ_TOL), .LOCK_TOL(LOCK_TOL))
  i_pbm_ctrl_monitor (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .BUS_I(BUS_I),
  .LOOP_ON_O(LOOP_ON_O), .TRACK_O(TRACK_O), .BASE_SEL_O(BASE_SEL_O), .PRESCALE_O(PRESCALE_O),
  .RANGE_EXP_O(RANGE_EXP_O), .MULT_O(MULT_O), .REF_DIV_O(REF_DIV_O),
  .LIN_RANGE_O(LIN_RANGE_O), .CENTRE_O(CENTRE_O), .LOCK_O(LOCK_O), .IRQ_O(IRQ_O));

// [pbm_ctrl_tb_top.sv]
// Purpose: register-level test of the loop bandwidth control
// Assumes: feedback clock made here, short averaging window
// Notes: R=4 makes a 4-cycle feedback period sit in lock
`timescale 1ns/1ns
`include "pbm_regs.svh"
module pbm_ctrl_tb_top;
  import pbm_pkg::*;
  logic        clk_sys, reset, fb_clk, fb_run, loop_on, track, base_sel, lock, irq;
  pbm_bus_type bus;
  logic [7:0]  rdata, lin, rd_val;
  logic [1:0]  pre, rexp;
  logic [11:0] mult;
  logic [3:0]  rdiv;
  logic [10:0] centre;
  int          err_count, total_checks, cycles;
  // Set before the feedback loop first counts, else it spins at time zero
  int          fb_half = 2;
  pbm_ctrl #(.AVG_EDGES(16'h0004), .ACQ_TOL(16'h0002), .LOCK_TOL(16'h0001)) i_pbm_ctrl (
    .CLK_SYS_I(clk_sys), .RESET_I(reset), .BUS_I(bus), .RDATA_O(rdata), .FB_CLK_I(fb_clk),
    .LOOP_ON_O(loop_on), .TRACK_O(track), .BASE_SEL_O(base_sel), .PRESCALE_O(pre),
    .RANGE_EXP_O(rexp), .MULT_O(mult), .REF_DIV_O(rdiv), .LIN_RANGE_O(lin),
    .CENTRE_O(centre), .LOCK_O(lock), .IRQ_O(irq));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Feedback clock stands low unless running
  initial forever begin
    repeat (fb_half) @(posedge clk_sys);
    fb_clk <= fb_run ? ~fb_clk : 1'b0;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1 rd_val = rdata;
    chk({8'h00, rd_val}, {8'h00, exp});
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_lock(input logic v);
    int n = 0;
    while (lock !== v && n < 400) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(16'(lock), 16'(v));
  endtask
  initial begin
    reset = 1'b1; bus = '0; fb_clk = 1'b0; fb_run = 1'b0; fb_half = 2;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1 chk(16'(centre), 16'h0040);
    rchk(`PBM_ADDR_CTRL, 8'h20); rchk(`PBM_ADDR_BW, 8'h00); rchk(`PBM_ADDR_MULH, 8'h00);
    rchk(`PBM_ADDR_MULL, 8'h40); rchk(`PBM_ADDR_LIN, 8'h40); rchk(`PBM_ADDR_RDIV, 8'h01);
    rchk(8'h40, 8'h00);
    // Parameters refused while the loop is on
    wr(`PBM_ADDR_MULL, 8'h08); rchk(`PBM_ADDR_MULL, 8'h40);
    wr(`PBM_ADDR_CTRL, 8'h2f); rchk(`PBM_ADDR_CTRL, 8'h20);
    wr(`PBM_ADDR_CTRL, 8'h00); wr(`PBM_ADDR_MULL, 8'h00); wr(`PBM_ADDR_RDIV, 8'h00); settle;
    chk({mult, rdiv}, 16'h0011);
    wr(`PBM_ADDR_CTRL, 8'h10); rchk(`PBM_ADDR_CTRL, 8'h00);
    wr(`PBM_ADDR_LIN, 8'h00); wr(`PBM_ADDR_CTRL, 8'h20); settle; chk(16'(loop_on), 16'h0);
    wr(`PBM_ADDR_CTRL, 8'h30); rchk(`PBM_ADDR_CTRL, 8'h20);
    wr(`PBM_ADDR_CTRL, 8'h00); wr(`PBM_ADDR_LIN, 8'h40); wr(`PBM_ADDR_MULL, 8'h08);
    wr(`PBM_ADDR_RDIV, 8'h04); wr(`PBM_ADDR_CTRL, 8'h06); settle;
    chk({mult, rdiv}, 16'h0084);
    chk(16'({pre, rexp}), 16'h0006);
    chk(16'(centre), 16'h0100);
    // Manual filter control
    wr(`PBM_ADDR_BW, 8'h20); settle; chk(16'(track), 16'h1);
    rchk(`PBM_ADDR_BW, 8'h20);
    wr(`PBM_ADDR_BW, 8'h00); settle; chk(16'(track), 16'h0);
    wr(`PBM_ADDR_CTRL, 8'h86); rchk(`PBM_ADDR_CTRL, 8'h06);
    // Base select guards power clear
    wr(`PBM_ADDR_CTRL, 8'h26); wr(`PBM_ADDR_CTRL, 8'h36); wr(`PBM_ADDR_CTRL, 8'h16); settle;
    chk(16'({loop_on, base_sel}), 16'h0003);
    rchk(`PBM_ADDR_CTRL, 8'h36);
    wr(`PBM_ADDR_CTRL, 8'h26);
    // Manual bring-up: wait, track, wait, then select the loop clock
    repeat (20) @(posedge clk_sys);
    wr(`PBM_ADDR_BW, 8'h20); settle; chk(16'(track), 16'h1);
    repeat (20) @(posedge clk_sys);
    wr(`PBM_ADDR_CTRL, 8'h36); settle; chk(16'(base_sel), 16'h1);
    wr(`PBM_ADDR_CTRL, 8'h26);
    // Automatic mode: lock, flag and interrupt both ways
    fb_run = 1'b1;
    wr(`PBM_ADDR_BW, 8'h80); wr(`PBM_ADDR_CTRL, 8'ha6); wait_lock(1'b1); settle;
    chk(16'({track, irq}), 16'h0003);
    wr(`PBM_ADDR_BW, 8'h80); settle; chk(16'(track), 16'h1);
    rchk(`PBM_ADDR_CTRL, 8'he6); rchk(`PBM_ADDR_CTRL, 8'ha6);
    chk(16'(irq), 16'h0);
    fb_half = 4;
    wait_lock(1'b0); settle;
    chk(16'({track, irq}), 16'h0001);
    rchk(`PBM_ADDR_CTRL, 8'he6);
    wr(`PBM_ADDR_BW, 8'h00); settle; chk(16'({lock, irq}), 16'h0);
    rchk(`PBM_ADDR_CTRL, 8'h26);
    tally_and_finish();
  end
endmodule
